/* fhq_pkg.sv */
// Purpose: shared constants and types of the flash protect/query host controller
// Assumes: 10 MHz system clock, 8-bit parallel flash with 21 address lines
// Notes: command codes for the unlock sequences are plain defaults

package fhq_pkg;

   // ------------------------------------------------------------------
   // widths and timing
   // ------------------------------------------------------------------
   localparam int ADDR_W = 21;
   localparam int DATA_W = 8;
   localparam int CLK_PERIOD_NS = 100;
   localparam int T_SETUP_NS = 50;
   localparam int T_WRITE_PULSE_NS = 35;
   localparam int T_READ_ACCESS_NS = 70;
   localparam int T_HOLD_NS = 20;
   localparam int T_RESET_PULSE_NS = 500;
   localparam int T_RESET_RECOVER_NS = 50;
   localparam int SETUP_CYC = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WPULSE_CYC = (T_WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RACCESS_CYC = (T_READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HOLD_CYC = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RPULSE_CYC = (T_RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RRECOVER_CYC = (T_RESET_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ------------------------------------------------------------------
   // command codes and addresses
   // ------------------------------------------------------------------
   localparam logic [ADDR_W-1:0] UNLOCK1_ADDR = 21'h000555;
   localparam logic [ADDR_W-1:0] UNLOCK2_ADDR = 21'h0002aa;
   localparam logic [DATA_W-1:0] UNLOCK1_DATA = 8'haa;
   localparam logic [DATA_W-1:0] UNLOCK2_DATA = 8'h55;
   localparam logic [DATA_W-1:0] CMD_PROGRAM = 8'ha0;
   localparam logic [DATA_W-1:0] CMD_ERASE_SETUP = 8'h80;
   localparam logic [DATA_W-1:0] CMD_SECTOR_ERASE = 8'h30;
   localparam logic [DATA_W-1:0] CMD_IDENTIFY = 8'h90;
   localparam logic [DATA_W-1:0] CMD_RESET = 8'hf0;
   localparam logic [ADDR_W-1:0] QUERY_ADDR = 21'h000055;
   localparam logic [DATA_W-1:0] CMD_QUERY = 8'h98;
   localparam logic [15:0] PROT_OFFSET = 16'h0002;
   localparam int GROUP_MSB = 20;
   localparam int GROUP_LSB = 18;
   localparam int SECTOR_LSB = 16;

   // ------------------------------------------------------------------
   // query signature
   // ------------------------------------------------------------------
   localparam logic [ADDR_W-1:0] QRY_ADDR0 = 21'h000010;
   localparam logic [ADDR_W-1:0] QRY_ADDR1 = 21'h000011;
   localparam logic [ADDR_W-1:0] QRY_ADDR2 = 21'h000012;
   localparam logic [DATA_W-1:0] QRY_CHAR0 = 8'h51;
   localparam logic [DATA_W-1:0] QRY_CHAR1 = 8'h52;
   localparam logic [DATA_W-1:0] QRY_CHAR2 = 8'h59;

   // ------------------------------------------------------------------
   // types
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {
      OP_READ = 3'h0,
      OP_PROGRAM = 3'h1,
      OP_ERASE = 3'h2,
      OP_QUERY = 3'h3,
      OP_RESET = 3'h4,
      OP_PROT_CHECK = 3'h5,
      OP_VID_ON = 3'h6,
      OP_VID_OFF = 3'h7
   } fhq_op_t;

   typedef struct packed {
      logic wr;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic last;
      logic check;
   } fhq_step_t;

endpackage

/* fhq_cyc_if.sv */
// Purpose: one bus cycle request and its completion, sequencer to engine
// Assumes: both ends on the same clock
// Notes: req and done are one-cycle pulses

`timescale 1ns/100ps

interface fhq_cyc_if;
   import fhq_pkg::*;
   logic req;
   logic wr;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic done;
   logic [DATA_W-1:0] rdata;

   modport seq (output req, output wr, output addr, output wdata, input done, input rdata);
   modport eng (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface

/* fhq_bus_engine.sv */
// Purpose: runs one read or write cycle on the flash pins
// Assumes: data input is synchronous to clk
// Notes: phases are setup, strobe, hold; every strobe lasts whole clock cycles

`timescale 1ns/100ps

module fhq_bus_engine
   import fhq_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   fhq_cyc_if.eng cyc,
   output logic ce_n,
   output logic we_n,
   output logic oe_n,
   output logic [ADDR_W-1:0] addr,
   output logic [DATA_W-1:0] data_out,
   output logic data_oe_n,
   input wire logic [DATA_W-1:0] data_in
);

   typedef enum logic [1:0] {
      E_IDLE = 2'b00,
      E_SETUP = 2'b01,
      E_STROBE = 2'b11,
      E_HOLD = 2'b10
   } fhq_eng_state_t;

   fhq_eng_state_t state_reg;
   logic [3:0] cnt_reg;
   logic wr_reg;

   // ------------------------------------------------------------------
   // phase sequencing
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= E_IDLE;
         cnt_reg <= 4'h0;
         wr_reg <= 1'b0;
      end else begin
         unique case (state_reg)
            E_IDLE: begin
               if (cyc.req) begin
                  state_reg <= E_SETUP;
                  wr_reg <= cyc.wr;
                  cnt_reg <= 4'(SETUP_CYC - 1);
               end
            end
            E_SETUP: begin
               if (cnt_reg == 4'h0) begin
                  state_reg <= E_STROBE;
                  cnt_reg <= wr_reg ? 4'(WPULSE_CYC - 1) : 4'(RACCESS_CYC - 1);
               end else begin
                  cnt_reg <= cnt_reg - 4'h1;
               end
            end
            E_STROBE: begin
               if (cnt_reg == 4'h0) begin
                  state_reg <= E_HOLD;
                  cnt_reg <= 4'(HOLD_CYC - 1);
               end else begin
                  cnt_reg <= cnt_reg - 4'h1;
               end
            end
            E_HOLD: begin
               if (cnt_reg == 4'h0) begin
                  state_reg <= E_IDLE;
               end else begin
                  cnt_reg <= cnt_reg - 4'h1;
               end
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // pin drive
   // ------------------------------------------------------------------
   // a write strobe never overlaps output enable, so the flash sees a clean
   // write: select and write strobe low, output enable high
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ce_n <= 1'b1;
         we_n <= 1'b1;
         oe_n <= 1'b1;
         addr <= '0;
         data_out <= '0;
         data_oe_n <= 1'b1;
      end else begin
         if (state_reg == E_IDLE && cyc.req) begin
            ce_n <= 1'b0;
            oe_n <= 1'b1;
            addr <= cyc.addr;
            data_out <= cyc.wdata;
            data_oe_n <= !cyc.wr;
         end
         if (state_reg == E_SETUP && cnt_reg == 4'h0) begin
            we_n <= !wr_reg;
            oe_n <= wr_reg;
         end
         // strobes are at least one full 100 ns period, far above noise width
         if (state_reg == E_STROBE && cnt_reg == 4'h0) begin
            we_n <= 1'b1;
            oe_n <= 1'b1;
         end
         if (state_reg == E_HOLD && cnt_reg == 4'h0) begin
            ce_n <= 1'b1;
            data_oe_n <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------------
   // completion and read capture
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cyc.done <= 1'b0;
         cyc.rdata <= '0;
      end else begin
         cyc.done <= (state_reg == E_HOLD && cnt_reg == 4'h0);
         if (state_reg == E_STROBE && cnt_reg == 4'h0 && !wr_reg) begin
            cyc.rdata <= data_in;
         end
      end
   end

endmodule

/* fhq_host.sv */
// Purpose: host controller for sector-group protection check, temporary unprotect and query
// Assumes: 10 MHz clk, flash pins sampled synchronously, external switch makes the
//          elevated voltage on the flash reset pin when flash_vid_en is high
// Notes: one user command at a time; answer is one rsp_valid pulse

`timescale 1ns/100ps

module fhq_host
   import fhq_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic cmd_valid,
   input wire logic [2:0] cmd_op,
   input wire logic [ADDR_W-1:0] cmd_addr,
   input wire logic [DATA_W-1:0] cmd_data,
   output logic cmd_ready,
   output logic rsp_valid,
   output logic [DATA_W-1:0] rsp_data,
   output logic rsp_err,
   output logic flash_ce_n,
   output logic flash_we_n,
   output logic flash_oe_n,
   output logic [ADDR_W-1:0] flash_addr,
   output logic [DATA_W-1:0] flash_data_out,
   output logic flash_data_oe_n,
   input wire logic [DATA_W-1:0] flash_data_in,
   output logic flash_reset_n,
   output logic flash_vid_en
);

   typedef enum logic [1:0] {
      S_INIT = 2'b00,
      S_IDLE = 2'b01,
      S_RUN = 2'b11,
      S_RESP = 2'b10
   } fhq_state_t;

   fhq_state_t state_reg;
   fhq_op_t op_reg;
   logic [ADDR_W-1:0] addr_reg;
   logic [DATA_W-1:0] data_reg;
   logic [2:0] idx_reg;
   logic wait_reg;
   logic [7:0] init_cnt_reg;
   fhq_step_t cur;
   logic accept;

   fhq_cyc_if cyc ();

   // ------------------------------------------------------------------
   // command sequences
   // ------------------------------------------------------------------
   function automatic fhq_step_t step_of(
      input fhq_op_t op,
      input logic [2:0] idx,
      input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d
   );
      fhq_step_t s;
      s = '{wr: 1'b1, addr: UNLOCK1_ADDR, data: UNLOCK1_DATA, last: 1'b0, check: 1'b0};
      // program, erase and identify all open with the two unlock writes
      if (idx == 3'h1) begin
         s.addr = UNLOCK2_ADDR;
         s.data = UNLOCK2_DATA;
      end
      unique case (op)
         OP_READ: begin
            s = '{wr: 1'b0, addr: a, data: '0, last: 1'b1, check: 1'b0};
         end
         OP_RESET: begin
            // also the way out of query and identification mode
            s = '{wr: 1'b1, addr: a, data: CMD_RESET, last: 1'b1, check: 1'b0};
         end
         OP_PROGRAM: begin
            if (idx == 3'h2) begin
               s.data = CMD_PROGRAM;
            end else if (idx == 3'h3) begin
               s = '{wr: 1'b1, addr: a, data: d, last: 1'b1, check: 1'b0};
            end
         end
         OP_ERASE: begin
            if (idx == 3'h2) begin
               s.data = CMD_ERASE_SETUP;
            end else if (idx == 3'h4) begin
               s.addr = UNLOCK2_ADDR;
               s.data = UNLOCK2_DATA;
            end else if (idx == 3'h5) begin
               s = '{wr: 1'b1, addr: a, data: CMD_SECTOR_ERASE, last: 1'b1, check: 1'b0};
            end
         end
         OP_QUERY: begin
            // entry write, then the signature is read back to confirm the mode
            if (idx == 3'h0) begin
               s = '{wr: 1'b1, addr: QUERY_ADDR, data: CMD_QUERY, last: 1'b0,
                     check: 1'b0};
            end else if (idx == 3'h1) begin
               s = '{wr: 1'b0, addr: QRY_ADDR0, data: QRY_CHAR0, last: 1'b0,
                     check: 1'b1};
            end else if (idx == 3'h2) begin
               s = '{wr: 1'b0, addr: QRY_ADDR1, data: QRY_CHAR1, last: 1'b0,
                     check: 1'b1};
            end else begin
               s = '{wr: 1'b0, addr: QRY_ADDR2, data: QRY_CHAR2, last: 1'b1,
                     check: 1'b1};
            end
         end
         OP_PROT_CHECK: begin
            if (idx == 3'h2) begin
               s.data = CMD_IDENTIFY;
            end else if (idx == 3'h3) begin
               // group bits and sector bits kept, offset two selects the flag
               s = '{wr: 1'b0, addr: {a[GROUP_MSB:SECTOR_LSB], PROT_OFFSET}, data: '0,
                     last: 1'b0, check: 1'b0};
            end else if (idx == 3'h4) begin
               s = '{wr: 1'b1, addr: a, data: CMD_RESET, last: 1'b1, check: 1'b0};
            end
         end
         OP_VID_ON, OP_VID_OFF: begin
            s.last = 1'b1;
         end
      endcase
      return s;
   endfunction

   assign cur = step_of(op_reg, idx_reg, addr_reg, data_reg);
   assign accept = (state_reg == S_IDLE) && cmd_valid;

   // ------------------------------------------------------------------
   // flash reset pulse after controller reset
   // ------------------------------------------------------------------
   // reset pin is low from controller reset, held for the pulse time, then
   // released; commands wait for the recovery time so the flash reads array
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         init_cnt_reg <= 8'h00;
         flash_reset_n <= 1'b0;
      end else if (state_reg == S_INIT) begin
         init_cnt_reg <= init_cnt_reg + 8'h01;
         if (init_cnt_reg == 8'(RPULSE_CYC - 1)) begin
            flash_reset_n <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------------
   // temporary unprotect
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         flash_vid_en <= 1'b0;
      end else if (accept && fhq_op_t'(cmd_op) == OP_VID_ON) begin
         flash_vid_en <= 1'b1;
      end else if (accept && fhq_op_t'(cmd_op) == OP_VID_OFF) begin
         flash_vid_en <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= S_INIT;
         op_reg <= OP_READ;
         addr_reg <= '0;
         data_reg <= '0;
         idx_reg <= 3'h0;
         wait_reg <= 1'b0;
         cmd_ready <= 1'b0;
         rsp_valid <= 1'b0;
      end else begin
         rsp_valid <= 1'b0;
         unique case (state_reg)
            S_INIT: begin
               if (init_cnt_reg == 8'(RPULSE_CYC + RRECOVER_CYC - 1)) begin
                  state_reg <= S_IDLE;
                  cmd_ready <= 1'b1;
               end
            end
            S_IDLE: begin
               if (cmd_valid) begin
                  op_reg <= fhq_op_t'(cmd_op);
                  addr_reg <= cmd_addr;
                  data_reg <= cmd_data;
                  idx_reg <= 3'h0;
                  cmd_ready <= 1'b0;
                  if (fhq_op_t'(cmd_op) == OP_VID_ON || fhq_op_t'(cmd_op) == OP_VID_OFF) begin
                     state_reg <= S_RESP;
                     rsp_valid <= 1'b1;
                  end else begin
                     state_reg <= S_RUN;
                  end
               end
            end
            S_RUN: begin
               if (!wait_reg) begin
                  wait_reg <= 1'b1;
               end else if (cyc.done) begin
                  wait_reg <= 1'b0;
                  if (cur.last) begin
                     state_reg <= S_RESP;
                     rsp_valid <= 1'b1;
                  end else begin
                     idx_reg <= idx_reg + 3'h1;
                  end
               end
            end
            S_RESP: begin
               state_reg <= S_IDLE;
               cmd_ready <= 1'b1;
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // cycle request
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cyc.req <= 1'b0;
         cyc.wr <= 1'b0;
         cyc.addr <= '0;
         cyc.wdata <= '0;
      end else begin
         cyc.req <= (state_reg == S_RUN) && !wait_reg;
         if (state_reg == S_RUN && !wait_reg) begin
            cyc.wr <= cur.wr;
            cyc.addr <= cur.addr;
            cyc.wdata <= cur.data;
         end
      end
   end

   // ------------------------------------------------------------------
   // answer capture
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rsp_data <= '0;
         rsp_err <= 1'b0;
      end else if (accept) begin
         rsp_err <= 1'b0;
      end else if (state_reg == S_RUN && wait_reg && cyc.done && !cur.wr) begin
         rsp_data <= cyc.rdata;
         if (cur.check && cyc.rdata != cur.data) begin
            rsp_err <= 1'b1;
         end
      end
   end

   fhq_bus_engine fhq_bus_engine_i (
      .clk(clk),
      .resetn(resetn),
      .cyc(cyc.eng),
      .ce_n(flash_ce_n),
      .we_n(flash_we_n),
      .oe_n(flash_oe_n),
      .addr(flash_addr),
      .data_out(flash_data_out),
      .data_oe_n(flash_data_oe_n),
      .data_in(flash_data_in)
   );

endmodule

/* fhq_host_assertions.sv */
// Purpose: pin and command-port checks for fhq_host
// Assumes: one clock domain, resetn asynchronous active low
// Notes: bound to every fhq_host instance
`timescale 1ns/100ps
module fhq_host_chk
   import fhq_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic cmd_valid,
   input wire logic [2:0] cmd_op,
   input wire logic cmd_ready,
   input wire logic rsp_valid,
   input wire logic flash_ce_n,
   input wire logic flash_we_n,
   input wire logic flash_oe_n,
   input wire logic [ADDR_W-1:0] flash_addr,
   input wire logic [DATA_W-1:0] flash_data_out,
   input wire logic flash_data_oe_n,
   input wire logic flash_vid_en
);
   // ---------------------------------------------
   // properties
   // ---------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   logic take;
   assign take = cmd_valid && cmd_ready;
   we_gate_a: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n)
      else $error("write strobe outside select");
   we_pulse_a: assert property ($fell(flash_we_n) |=> flash_we_n && $stable(flash_data_out))
      else $error("write pulse malformed");
   rsp_pulse_a: assert property (rsp_valid |=> !rsp_valid && cmd_ready)
      else $error("response not a single pulse");
   read_time_a: assert property (take && cmd_op == 3'h0 |-> ##[7:8] rsp_valid)
      else $error("read answer late");
   vid_on_a: assert property (take && cmd_op == 3'h6 |-> ##[1:2] flash_vid_en)
      else $error("elevated voltage not raised");
   vid_off_a: assert property (take && cmd_op == 3'h7 |-> ##[1:2] !flash_vid_en)
      else $error("elevated voltage not removed");
   query_cmd_a: assert property (take && cmd_op == 3'h3 |-> ##[1:12] (!flash_we_n &&
      flash_addr == QUERY_ADDR && flash_data_out == CMD_QUERY))
      else $error("query command not written");
   unlock_write_a: assert property (take && (cmd_op == 3'h1 || cmd_op == 3'h2) |-> ##[1:12]
      (!flash_we_n && flash_addr == UNLOCK1_ADDR && flash_data_out == UNLOCK1_DATA))
      else $error("first unlock write missing");
   exit_cmd_a: assert property (take && cmd_op == 3'h4 |-> ##[1:12]
      (!flash_we_n && flash_data_out == CMD_RESET))
      else $error("reset command not written");
   // host data drive only while selected with output enable high, so no contention
   data_drive_a: assert property (!flash_data_oe_n |-> !flash_ce_n && flash_oe_n)
      else $error("data driven outside a write");
   vid_hold_a: assert property (flash_vid_en && !(take && cmd_op == 3'h7) |=> flash_vid_en)
      else $error("elevated voltage dropped unasked");
   cover property (take && cmd_op == 3'h3);
   cover property (take && cmd_op == 3'h2);
   cover property (flash_vid_en && !flash_we_n);
endmodule
bind fhq_host fhq_host_chk fhq_host_chk_i (.*);

/* fhq_flash_model.sv */
// Purpose: behavioural 8-bit parallel flash seen from its pins
// Assumes: protection bits are set by the bench, as programming equipment would
// Notes: event driven on the strobes, no clock; erased bytes read ffh
`timescale 1ns/100ps
module fhq_flash_model
   import fhq_pkg::*;
(
   input wire logic flash_ce_n,
   input wire logic flash_we_n,
   input wire logic flash_oe_n,
   input wire logic [ADDR_W-1:0] flash_addr,
   input wire logic [DATA_W-1:0] flash_data_in,
   output logic [DATA_W-1:0] dev_dq,
   input wire logic flash_reset_n,
   input wire logic flash_vid_en
);
   // ---------------------------------------------
   // query table {offset, byte} and state
   // ---------------------------------------------
   localparam logic [15:0] QT [24] = '{
      16'h1051, 16'h1152, 16'h1259, 16'h1302, 16'h1540, 16'h1b45,
      16'h1c55, 16'h1f03, 16'h210a, 16'h2305, 16'h2504, 16'h2715,
      16'h2c01, 16'h2d1f, 16'h3001, 16'h4050, 16'h4152, 16'h4249,
      16'h4331, 16'h4431, 16'h4602, 16'h4704, 16'h4801, 16'h4904};
   logic [7:0] mem [logic [ADDR_W-1:0]];
   logic [7:0] prot = 8'h00;
   logic supply_ok = 1'b0;
   logic armed = 1'b0;
   logic [7:0] rd = 8'h00;
   logic [7:0] junk = 8'ha5;
   int mode = 0;
   int back = 0;
   int ucnt = 0;
   realtime t_fall = 0;
   initial #300 supply_ok = 1'b1;
   function automatic logic [7:0] qry(input logic [6:0] a);
      qry = 8'h00;
      foreach (QT[i]) if (QT[i][14:8] == a) qry = QT[i][7:0];
   endfunction
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      logic ok;
      logic [ADDR_W-1:0] kq[$];
      ok = !prot[a[20:18]] || flash_vid_en;
      if (ucnt == 6) begin
         if (ok) mem[a] = d;
         ucnt = 0;
      end else if (ucnt == 5 && d == CMD_SECTOR_ERASE) begin
         foreach (mem[k]) if (ok && k[20:16] == a[20:16]) kq.push_back(k);
         foreach (kq[i]) mem.delete(kq[i]);
         ucnt = 0;
      end else if (d == CMD_QUERY && a[7:0] == 8'h55 && mode < 2) begin
         back = mode;
         mode = 2;
      end else if (d == CMD_RESET) begin
         mode = (mode == 2) ? back : 0;
         ucnt = 0;
      end else if (ucnt % 3 == 0 && a == UNLOCK1_ADDR && d == UNLOCK1_DATA) ucnt++;
      else if (ucnt % 3 == 1 && a == UNLOCK2_ADDR && d == UNLOCK2_DATA) ucnt++;
      else if (ucnt == 2 && d == CMD_PROGRAM) ucnt = 6;
      else if (ucnt == 2 && d == CMD_ERASE_SETUP) ucnt = 3;
      else if (ucnt == 2 && d == CMD_IDENTIFY) mode = 1;
      else ucnt = 0;
   endtask
   always @(negedge flash_reset_n or negedge supply_ok) begin
      mode = 0;
      ucnt = 0;
   end
   // a strobe that fell before the supply was good never writes
   always @(negedge flash_we_n) begin
      t_fall = $realtime;
      armed = supply_ok;
   end
   always @(posedge flash_we_n) begin
      if (armed && supply_ok && flash_reset_n && !flash_ce_n && flash_oe_n
         && $realtime - t_fall >= 5.0) wr(flash_addr, flash_data_in);
   end
   always @(negedge flash_oe_n) begin
      if (mode == 2) rd = qry(flash_addr[6:0]);
      else if (mode == 1) rd = {7'h00, flash_addr[15:0] == PROT_OFFSET && prot[flash_addr[20:18]]};
      else rd = mem.exists(flash_addr) ? mem[flash_addr] : 8'hff;
   end
   // released lines show the inverse of the last byte, never a stale copy
   always @(posedge flash_oe_n) junk = ~rd;
   assign dev_dq = (!flash_ce_n && !flash_oe_n && flash_reset_n) ? rd : junk;
endmodule

/* test_flash_protect_and_query.sv */
// Purpose: self-checking bench for fhq_host driving a behavioural flash
// Assumes: 10 MHz clock, inputs change on the falling edge
// Notes: expectations {skip, err, data} are queued by the driver
`timescale 1ns/100ps
module test_flash_protect_and_query
   import fhq_pkg::*;
;
   localparam logic [9:0] SKIP = 10'h200;
   logic clk, resetn, cmd_valid, cmd_ready, rsp_valid, rsp_err;
   logic flash_ce_n, flash_we_n, flash_oe_n, flash_data_oe_n, flash_reset_n, flash_vid_en;
   logic [2:0] cmd_op;
   logic [ADDR_W-1:0] cmd_addr, flash_addr, a;
   logic [DATA_W-1:0] cmd_data, rsp_data, flash_data_out, flash_data_in, dev_dq, d;
   logic [15:0] qe;
   logic [9:0] exp_q[$];
   int mismatches = 0;
   int comparisons = 0;
   assign flash_data_in = !flash_data_oe_n ? flash_data_out : dev_dq;
   fhq_host fhq_host_i (.*);
   fhq_flash_model fhq_flash_model_i (.*);
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // ---------------------------------------------
   // tasks
   // ---------------------------------------------
   task automatic check(input string what, input logic [8:0] seen, input logic [8:0] expd);
      comparisons++;
      if (seen !== expd) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, expd, seen);
      end
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic bail();
      mismatches++;
      give_verdict();
   endtask
   task automatic issue(input logic [2:0] op, input logic [ADDR_W-1:0] ad,
      input logic [DATA_W-1:0] dt, input logic [9:0] e);
      int n;
      n = 0;
      @(negedge clk);
      while (cmd_ready !== 1'b1) begin
         n++;
         if (n > 400) bail();
         @(negedge clk);
      end
      exp_q.push_back(e);
      cmd_valid = 1'b1;
      cmd_op = op;
      cmd_addr = ad;
      cmd_data = dt;
      @(negedge clk);
      cmd_valid = 1'b0;
   endtask
   task automatic done(input string s);
      int n;
      n = 0;
      while (exp_q.size() != 0) begin
         n++;
         if (n > 400) bail();
         @(negedge clk);
      end
      $display("test %s finished", s);
   endtask
   always @(negedge clk) begin
      if (rsp_valid === 1'b1) begin
         if (exp_q.size() == 0) check("spare response", 9'h1ff, 9'h000);
         else begin
            if (!exp_q[0][9]) check("response", {rsp_err, rsp_data}, exp_q[0][8:0]);
            void'(exp_q.pop_front());
         end
      end
   end
   initial begin
      cmd_valid = 1'b0;
      cmd_op = 3'h0;
      cmd_addr = '0;
      cmd_data = '0;
      resetn = 1'b0;
      void'($urandom(32'hd7ad));
      repeat (12) @(posedge clk);
      @(negedge clk);
      resetn = 1'b1;
      issue(3'h3, '0, '0, 10'h059);
      foreach (fhq_flash_model_i.QT[i]) begin
         qe = fhq_flash_model_i.QT[i];
         issue(3'h0, 21'(qe[15:8]), '0, {2'b00, qe[7:0]});
      end
      issue(3'h0, 21'h000035, '0, 10'h000);
      issue(3'h0, 21'h1f0047, '0, 10'h004);
      issue(3'h4, '0, '0, SKIP);
      issue(3'h0, 21'h000010, '0, 10'h0ff);
      done("query");
      repeat (3) begin
         a = 21'($urandom_range(32'h1bffff));
         d = 8'($urandom);
         issue(3'h1, a, d, SKIP);
         issue(3'h0, a, '0, {2'b00, d});
      end
      fhq_flash_model_i.prot[7] = 1'b1;
      issue(3'h5, 21'h1c0000, '0, 10'h001);
      issue(3'h5, 21'h1bffff, '0, 10'h000);
      issue(3'h1, 21'h1c1234, 8'h3c, SKIP);
      issue(3'h0, 21'h1c1234, '0, 10'h0ff);
      issue(3'h1, 21'h1bffff, 8'h5a, SKIP);
      issue(3'h0, 21'h1bffff, '0, 10'h05a);
      done("protect");
      issue(3'h6, '0, '0, SKIP);
      issue(3'h1, 21'h1c1234, 8'h3c, SKIP);
      issue(3'h0, 21'h1c1234, '0, 10'h03c);
      issue(3'h7, '0, '0, SKIP);
      issue(3'h2, 21'h1c0000, '0, SKIP);
      issue(3'h0, 21'h1c1234, '0, 10'h03c);
      issue(3'h5, 21'h1c0000, '0, 10'h001);
      done("temporary unprotect");
      fhq_flash_model_i.prot[7] = 1'b0;
      issue(3'h2, 21'h1c0000, '0, SKIP);
      issue(3'h0, 21'h1c1234, '0, 10'h0ff);
      done("unprotect");
      fhq_flash_model_i.supply_ok = 1'b0;
      issue(3'h3, '0, '0, 10'h1ff);
      issue(3'h1, 21'h000100, 8'h11, SKIP);
      done("lockout writes");
      fhq_flash_model_i.supply_ok = 1'b1;
      issue(3'h0, 21'h000100, '0, 10'h0ff);
      done("lockout read");
      give_verdict();
   end
endmodule
